// *** verilog/axenc_top.sv ***
// Behaviour
// - Count up when A leads, down when B leads
// - Each phase edge moves count by one
// - One output edge per internal count
// - Codes 44 and 45 select incremental operation
// - Code 48: Gray or binary, up to 25 bits
// - Serial frame carries n plus two pulses
// - Frames repeat continuously once count programmed
// - Serial clock fixed at 200 kHz
// - Serial clock idles 32 us between frames
// - Received word becomes measured position and error
// - Request link 1 MHz, encoder answers requests
// - Position request every 250 us
// - Absolute links refuse the 0.25 ms period
// - Request link words up to 32 bits
// - Decoder follows 6 MHz edge rates
`timescale 1ns/100ps
`default_nettype none
module axenc_top #(
  parameter int RR_CYCLE = axenc_pkg::RR_CYCLE_CYC
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [7:0] AXIS_TYPE_SELECT,
  input wire logic [1:0] SERVO_PERIOD_SEL,
  input wire logic [4:0] SSI_BIT_COUNT,
  input wire logic GRAY_SELECT,
  input wire logic [5:0] RR_BIT_COUNT,
  input wire logic [31:0] DEMAND_POSITION,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_Z,
  input wire logic SSI_DATA,
  input wire logic RR_DATA_IN,
  output logic SSI_CLK,
  output logic RR_CLK,
  output logic RR_DATA_OUT,
  output logic RR_DATA_OE,
  output logic QOUT_A,
  output logic QOUT_B,
  output logic [31:0] MEASURED_POSITION,
  output logic [31:0] POSITION_ERROR,
  output logic POSITION_VALID,
  output logic [31:0] INDEX_POSITION,
  output logic PERIOD_ERROR
);
  import axenc_pkg::*;

  generate
    if (RR_CYCLE < 64 || RR_CYCLE > 32767) begin : g_chk
      $error("request cycle out of range");
    end
  endgenerate

  function automatic logic [31:0] gray2bin(input logic [31:0] g);
    logic [31:0] r;
    r = g;
    for (int i = 30; i >= 0; i--) begin
      r[i] = r[i+1] ^ g[i];
    end
    return r;
  endfunction : gray2bin

  // ***************************************************
  // Pin synchronisers: A, B, Z, serial data, request data
  // ***************************************************
  logic [4:0] pin_in, s1_r, s2_r;
  assign pin_in = {RR_DATA_IN, SSI_DATA, ENC_Z, ENC_B, ENC_A};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate
  logic ssi_dat, rr_dat;
  assign ssi_dat = s2_r[3];
  assign rr_dat = s2_r[4];

  // ***************************************************
  // Mode decode
  // ***************************************************
  logic inc_mode, ssi_mode, rr_mode, slow_ok, ssi_run, rr_run;
  assign inc_mode = AXIS_TYPE_SELECT == AXT_SERVO || AXIS_TYPE_SELECT == AXT_ENC_OUT;
  assign ssi_mode = AXIS_TYPE_SELECT == AXT_SSI_ABS;
  assign rr_mode = AXIS_TYPE_SELECT == AXT_RR_ABS;
  assign slow_ok = SERVO_PERIOD_SEL != SERVO_250US;
  assign ssi_run = ssi_mode && slow_ok && SSI_BIT_COUNT != 5'h00
    && 32'(SSI_BIT_COUNT) <= SSI_MAX_BITS;
  assign rr_run = rr_mode && slow_ok && RR_BIT_COUNT != 6'h00
    && 32'(RR_BIT_COUNT) <= RR_MAX_BITS;

  // ***************************************************
  // Incremental decoder and pulse output
  // ***************************************************
  // Two-stage sync plus one-cycle compare resolves 6 MHz edges at 100 MHz
  logic [31:0] qcnt, qidx;
  axenc_qdec #(.W(32)) u_qdec (
    .clk(REF_CLK),
    .nrst(NRST),
    .a(s2_r[0]),
    .b(s2_r[1]),
    .z(s2_r[2]),
    .cnt_r(qcnt),
    .idx_r(qidx)
  );
  axenc_qout #(.W(32), .EDGE_CYC(QOUT_EDGE_CYC)) u_qout (
    .clk(REF_CLK),
    .nrst(NRST),
    .en(AXIS_TYPE_SELECT == AXT_ENC_OUT),
    .target(MEASURED_POSITION),
    .qa_r(QOUT_A),
    .qb_r(QOUT_B)
  );

  // ***************************************************
  // Synchronous-serial master
  // ***************************************************
  axenc_ssi_t ssi_st_r, ssi_st_nxt;
  logic [11:0] ssi_tmr_r, ssi_tmr_nxt;
  logic [4:0] ssi_pls_r, ssi_pls_nxt, nb;
  logic [24:0] ssi_sh_r, ssi_sh_nxt;
  logic ssi_clk_nxt, ssi_done;
  assign nb = SSI_BIT_COUNT;

  always_comb begin
    ssi_st_nxt = ssi_st_r;
    ssi_tmr_nxt = ssi_tmr_r + 12'h001;
    ssi_clk_nxt = SSI_CLK;
    ssi_pls_nxt = ssi_pls_r;
    ssi_sh_nxt = ssi_sh_r;
    ssi_done = 1'b0;
    if (!ssi_run) begin
      ssi_st_nxt = SSI_GAP;
      ssi_tmr_nxt = 12'h000;
      ssi_clk_nxt = 1'b1;
      ssi_pls_nxt = 5'h00;
    end else begin
      case (ssi_st_r)
        SSI_GAP: begin
          if (32'(ssi_tmr_r) == SSI_GAP_CYC - 1) begin
            ssi_st_nxt = SSI_LOW;
            ssi_tmr_nxt = 12'h000;
            ssi_clk_nxt = 1'b0;
            ssi_pls_nxt = 5'h00;
            ssi_sh_nxt = '0;
          end
        end
        SSI_LOW: begin
          if (32'(ssi_tmr_r) == SSI_HALF_CYC - 1) begin
            ssi_tmr_nxt = 12'h000;
            ssi_clk_nxt = 1'b1;
            if (ssi_pls_r != 5'h00 && ssi_pls_r <= nb) begin
              ssi_sh_nxt = {ssi_sh_r[23:0], ssi_dat};
            end
            if (ssi_pls_r == nb + 5'h01) begin
              ssi_st_nxt = SSI_GAP;
              ssi_done = 1'b1;
            end else begin
              ssi_st_nxt = SSI_HIGH;
            end
          end
        end
        SSI_HIGH: begin
          if (32'(ssi_tmr_r) == SSI_HALF_CYC - 1) begin
            ssi_st_nxt = SSI_LOW;
            ssi_tmr_nxt = 12'h000;
            ssi_clk_nxt = 1'b0;
            ssi_pls_nxt = ssi_pls_r + 5'h01;
          end
        end
        default: ssi_st_nxt = SSI_GAP;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ssi_st_r <= SSI_GAP;
      ssi_tmr_r <= 12'h000;
      SSI_CLK <= 1'b1;
      ssi_pls_r <= 5'h00;
      ssi_sh_r <= '0;
    end else begin
      ssi_st_r <= ssi_st_nxt;
      ssi_tmr_r <= ssi_tmr_nxt;
      SSI_CLK <= ssi_clk_nxt;
      ssi_pls_r <= ssi_pls_nxt;
      ssi_sh_r <= ssi_sh_nxt;
    end
  end

  // ***************************************************
  // Request/response master
  // ***************************************************
  // Requests are paced by a free-running timer, so a late answer never drifts
  // the 250 us grid; a request due while a frame is still busy is skipped.
  axenc_rr_t rr_st_r, rr_st_nxt;
  logic [14:0] rr_cyc_r, rr_cyc_nxt;
  logic [6:0] rr_tmr_r, rr_tmr_nxt;
  logic [5:0] rr_bit_r, rr_bit_nxt, rr_cmd_r, rr_cmd_nxt;
  logic [31:0] rr_sh_r, rr_sh_nxt;
  logic rr_clk_nxt, rr_out_nxt, rr_oe_nxt, rr_done, rr_kick, rr_tick;
  assign rr_kick = 32'(rr_cyc_r) == RR_CYCLE - 1;
  assign rr_tick = 32'(rr_tmr_r) == RR_HALF_CYC - 1;

  always_comb begin
    rr_st_nxt = rr_st_r;
    rr_cyc_nxt = rr_kick ? 15'h0000 : rr_cyc_r + 15'h0001;
    rr_tmr_nxt = rr_tick ? 7'h00 : rr_tmr_r + 7'h01;
    rr_bit_nxt = rr_bit_r;
    rr_cmd_nxt = rr_cmd_r;
    rr_sh_nxt = rr_sh_r;
    rr_clk_nxt = RR_CLK;
    rr_out_nxt = RR_DATA_OUT;
    rr_oe_nxt = RR_DATA_OE;
    rr_done = 1'b0;
    if (!rr_run) begin
      rr_st_nxt = RR_WAIT;
      rr_cyc_nxt = 15'h0000;
      rr_clk_nxt = 1'b1;
      rr_oe_nxt = 1'b0;
      rr_out_nxt = 1'b0;
    end else if (rr_st_r == RR_WAIT) begin
      if (rr_kick) begin
        rr_st_nxt = RR_CMD;
        rr_tmr_nxt = 7'h00;
        rr_bit_nxt = 6'h00;
        rr_clk_nxt = 1'b0;
        rr_oe_nxt = 1'b1;
        rr_cmd_nxt = RR_CMD_POS;
        rr_out_nxt = RR_CMD_POS[5];
      end
    end else if (rr_tick) begin
      rr_clk_nxt = !RR_CLK;
      case (rr_st_r)
        RR_CMD: begin
          if (RR_CLK) begin
            rr_bit_nxt = rr_bit_r + 6'h01;
            rr_cmd_nxt = {rr_cmd_r[4:0], 1'b0};
            rr_out_nxt = rr_cmd_r[4];
            if (32'(rr_bit_r) == RR_CMD_BITS - 1) begin
              rr_st_nxt = RR_RESP;
              rr_oe_nxt = 1'b0;
              rr_out_nxt = 1'b0;
              rr_bit_nxt = 6'h00;
            end
          end
        end
        RR_RESP: begin
          if (!RR_CLK) begin
            rr_bit_nxt = rr_bit_r + 6'h01;
            if (rr_dat) begin
              rr_st_nxt = RR_DATA;
              rr_bit_nxt = 6'h00;
              rr_sh_nxt = '0;
            end else if (32'(rr_bit_r) == RR_START_TIMEOUT - 1) begin
              rr_st_nxt = RR_WAIT;
            end
          end
        end
        RR_DATA: begin
          if (!RR_CLK) begin
            rr_sh_nxt = {rr_sh_r[30:0], rr_dat};
            rr_bit_nxt = rr_bit_r + 6'h01;
            if (rr_bit_r == RR_BIT_COUNT - 6'h01) begin
              rr_st_nxt = RR_WAIT;
              rr_done = 1'b1;
            end
          end
        end
        default: rr_st_nxt = RR_WAIT;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rr_st_r <= RR_WAIT;
      rr_cyc_r <= 15'h0000;
      rr_tmr_r <= 7'h00;
      rr_bit_r <= 6'h00;
      rr_cmd_r <= 6'h00;
      rr_sh_r <= '0;
      RR_CLK <= 1'b1;
      RR_DATA_OUT <= 1'b0;
      RR_DATA_OE <= 1'b0;
    end else begin
      rr_st_r <= rr_st_nxt;
      rr_cyc_r <= rr_cyc_nxt;
      rr_tmr_r <= rr_tmr_nxt;
      rr_bit_r <= rr_bit_nxt;
      rr_cmd_r <= rr_cmd_nxt;
      rr_sh_r <= rr_sh_nxt;
      RR_CLK <= rr_clk_nxt;
      RR_DATA_OUT <= rr_out_nxt;
      RR_DATA_OE <= rr_oe_nxt;
    end
  end

  // ***************************************************
  // Measured position and error
  // ***************************************************
  logic [31:0] meas_nxt, ssi_word;
  logic valid_nxt;
  assign ssi_word = GRAY_SELECT ? gray2bin({7'h00, ssi_sh_nxt})
    : {7'h00, ssi_sh_nxt};

  always_comb begin
    meas_nxt = MEASURED_POSITION;
    valid_nxt = 1'b0;
    if (inc_mode) begin
      meas_nxt = qcnt;
      valid_nxt = 1'b1;
    end else if (ssi_done) begin
      meas_nxt = ssi_word;
      valid_nxt = 1'b1;
    end else if (rr_done) begin
      meas_nxt = rr_sh_nxt;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      MEASURED_POSITION <= POS_RESET;
      POSITION_ERROR <= POS_RESET;
      POSITION_VALID <= 1'b0;
      INDEX_POSITION <= POS_RESET;
      PERIOD_ERROR <= 1'b0;
    end else begin
      MEASURED_POSITION <= meas_nxt;
      POSITION_ERROR <= DEMAND_POSITION - meas_nxt;
      POSITION_VALID <= valid_nxt;
      INDEX_POSITION <= qidx;
      PERIOD_ERROR <= (ssi_mode || rr_mode) && !slow_ok;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  logic [15:0] hi_len_r, lo_len_r, rr_gap_r;
  logic [5:0] fall_cnt_r;
  logic rr_seen_r;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      hi_len_r <= 16'h0000;
      lo_len_r <= 16'h0000;
      fall_cnt_r <= 6'h00;
      rr_gap_r <= 16'h0000;
      rr_seen_r <= 1'b0;
    end else begin
      hi_len_r <= SSI_CLK ? ((hi_len_r == 16'hffff) ? hi_len_r : hi_len_r + 16'h0001) : 16'h0000;
      lo_len_r <= SSI_CLK ? 16'h0000 : lo_len_r + 16'h0001;
      // An aborted frame must not carry its falls into the next one
      fall_cnt_r <= (ssi_done || !ssi_run) ? 6'h00 : fall_cnt_r + 6'(SSI_CLK && !ssi_clk_nxt);
      rr_gap_r <= (!rr_run || $rose(RR_DATA_OE)) ? 16'h0001 : rr_gap_r + 16'h0001;
      rr_seen_r <= rr_run && (rr_seen_r || $rose(RR_DATA_OE));
    end
  end

  sequence s_ssi_frame_end;
    ssi_done ##1 SSI_CLK;
  endsequence
  a_ssi_pulses: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ssi_done |-> 32'(fall_cnt_r) == 32'(nb) + 2)
    else $error("serial frame pulse count wrong");
  a_ssi_low_half: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(SSI_CLK) && $past(ssi_run) |-> 32'(lo_len_r) == SSI_HALF_CYC)
    else $error("serial clock low time wrong");
  a_ssi_high_half: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(SSI_CLK) && ssi_pls_nxt != 5'h00 |-> 32'(hi_len_r) == SSI_HALF_CYC)
    else $error("serial clock high time wrong");
  a_ssi_gap_idle: assert property (@(posedge REF_CLK) disable iff (!NRST)
    s_ssi_frame_end |-> SSI_CLK [*8] ##1 (ssi_st_r == SSI_GAP))
    else $error("serial clock not idle after frame");
  a_ssi_gap_len: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(SSI_CLK) && ssi_pls_r == 5'h00 |-> 32'(hi_len_r) >= SSI_GAP_CYC)
    else $error("inter-frame gap too short");
  a_ssi_refused: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !ssi_run |=> SSI_CLK && ssi_st_r == SSI_GAP)
    else $error("serial clock ran without setup");
  a_rr_cycle: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(RR_DATA_OE) && rr_seen_r |-> 32'(rr_gap_r) == RR_CYCLE)
    else $error("request spacing wrong");
  a_rr_release: assert property (@(posedge REF_CLK) disable iff (!NRST)
    RR_DATA_OE |-> rr_st_r == RR_CMD)
    else $error("data line driven outside request");
  a_fast_period: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (SERVO_PERIOD_SEL == SERVO_250US) [*2] |-> RR_CLK && SSI_CLK && !RR_DATA_OE)
    else $error("absolute link ran at fast period");
endmodule : axenc_top
`default_nettype wire

// *** verilog/axenc_pkg.sv ***
`default_nettype none
package axenc_pkg;
  // ***************************************************
  // Axis type codes and servo period code
  // ***************************************************
  localparam logic [7:0] AXT_SERVO = 8'h2c;
  localparam logic [7:0] AXT_ENC_OUT = 8'h2d;
  localparam logic [7:0] AXT_RR_ABS = 8'h2f;
  localparam logic [7:0] AXT_SSI_ABS = 8'h30;
  localparam logic [1:0] SERVO_250US = 2'h0;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SSI_RATE_KHZ = 200;
  localparam int SSI_HALF_CYC = 1000000 / (2 * SSI_RATE_KHZ * CLK_PERIOD_NS);
  localparam int SSI_GAP_NS = 32000;
  localparam int SSI_GAP_CYC = (SSI_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RR_RATE_KHZ = 1000;
  localparam int RR_HALF_CYC = 1000000 / (2 * RR_RATE_KHZ * CLK_PERIOD_NS);
  localparam int RR_CYCLE_US = 250;
  localparam int RR_CYCLE_CYC = RR_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam int QOUT_EDGE_NS = 125;
  localparam int QOUT_EDGE_CYC = (QOUT_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ***************************************************
  // Word sizes and request/response framing
  // ***************************************************
  localparam int SSI_MAX_BITS = 25;
  localparam int RR_MAX_BITS = 32;
  localparam int RR_CMD_BITS = 6;
  localparam logic [5:0] RR_CMD_POS = 6'h07;
  localparam int RR_START_TIMEOUT = 16;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  // ***************************************************
  // State machines
  // ***************************************************
  typedef enum logic [2:0] {
    SSI_GAP = 3'b001,
    SSI_LOW = 3'b010,
    SSI_HIGH = 3'b100
  } axenc_ssi_t;
  typedef enum logic [3:0] {
    RR_WAIT = 4'b0001,
    RR_CMD = 4'b0010,
    RR_RESP = 4'b0100,
    RR_DATA = 4'b1000
  } axenc_rr_t;
endpackage : axenc_pkg
`default_nettype wire

// *** verilog/axenc_qdec.sv ***
`timescale 1ns/100ps
`default_nettype none
module axenc_qdec #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic a,
  input wire logic b,
  input wire logic z,
  output logic [W-1:0] cnt_r,
  output logic [W-1:0] idx_r
);
  import axenc_pkg::*;
  logic a_r, b_r, z_r;
  logic [W-1:0] cnt_nxt, idx_nxt;
  logic [1:0] st;

  generate
    if (W < 2) begin : g_chk
      $error("counter too narrow");
    end
  endgenerate

  // Returns {one phase moved, forward}
  function automatic logic [1:0] qstep(input logic pa, pb, ca, cb);
    qstep = {(pa ^ ca) ^ (pb ^ cb), ca ^ pb};
  endfunction : qstep

  always_comb begin
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    st = qstep(a_r, b_r, a, b);
    if (st[1]) begin
      cnt_nxt = st[0] ? cnt_r + W'(1) : cnt_r - W'(1);
    end
    if (z && !z_r) begin
      idx_nxt = cnt_r;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      z_r <= 1'b0;
      cnt_r <= '0;
      idx_r <= '0;
    end else begin
      a_r <= a;
      b_r <= b;
      z_r <= z;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
    end
  end

  a_cnt_forward: assert property (@(posedge clk) disable iff (!nrst)
    (!a_r && !b_r && a && !b) |=> cnt_r == $past(cnt_r) + W'(1))
    else $error("forward edge did not increment");
  a_cnt_unit: assert property (@(posedge clk) disable iff (!nrst)
    ((a_r != a) || (b_r != b)) && !((a_r != a) && (b_r != b))
      |=> (cnt_r - $past(cnt_r) == W'(1)) || ($past(cnt_r) - cnt_r == W'(1)))
    else $error("edge did not move count by one");
endmodule : axenc_qdec
`default_nettype wire

// *** verilog/axenc_qout.sv ***
`timescale 1ns/100ps
`default_nettype none
module axenc_qout #(
  parameter int W = 32,
  parameter int EDGE_CYC = 13
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [W-1:0] target,
  output logic qa_r,
  output logic qb_r
);
  import axenc_pkg::*;
  logic [W-1:0] pos_r, pos_nxt;
  logic [7:0] tmr_r, tmr_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic qa_nxt, qb_nxt;

  generate
    if (EDGE_CYC < 1 || EDGE_CYC > 255) begin : g_chk
      $error("edge spacing out of range");
    end
  endgenerate

  // Paced walk toward the target keeps the output under its edge-rate limit
  always_comb begin
    pos_nxt = pos_r;
    ph_nxt = ph_r;
    tmr_nxt = (tmr_r == 8'h00) ? 8'h00 : tmr_r - 8'h01;
    if (!en) begin
      pos_nxt = target;
    end else if (tmr_r == 8'h00 && pos_r != target) begin
      tmr_nxt = 8'(EDGE_CYC - 1);
      if ($signed(target - pos_r) > 0) begin
        pos_nxt = pos_r + W'(1);
        ph_nxt = ph_r + 2'h1;
      end else begin
        pos_nxt = pos_r - W'(1);
        ph_nxt = ph_r - 2'h1;
      end
    end
    qa_nxt = ph_nxt[1] ^ ph_nxt[0];
    qb_nxt = ph_nxt[1];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_r <= '0;
      ph_r <= 2'h0;
      tmr_r <= 8'h00;
      qa_r <= 1'b0;
      qb_r <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      ph_r <= ph_nxt;
      tmr_r <= tmr_nxt;
      qa_r <= qa_nxt;
      qb_r <= qb_nxt;
    end
  end

  a_qout_one_edge: assert property (@(posedge clk) disable iff (!nrst)
    (pos_r != $past(pos_r) && en && $past(en))
      |-> ((qa_r != $past(qa_r)) != (qb_r != $past(qb_r))))
    else $error("count step without exactly one output edge");
endmodule : axenc_qout
`default_nettype wire

// *** bench/axenc_enc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module axenc_enc_model (
  input wire logic ssi_clk,
  input wire logic [4:0] ssi_bits,
  input wire logic [31:0] ssi_word,
  output logic ssi_data,
  input wire logic rr_clk,
  input wire logic rr_oe,
  input wire logic [5:0] rr_bits,
  input wire logic [31:0] rr_word,
  output logic rr_data
);
  time t_rise = 0;
  int k = 0;
  int j = -1;
  logic [31:0] sw;
  logic [31:0] rw;
  initial begin
    ssi_data = 1'b1;
    rr_data = 1'b0;
  end
  always @(posedge ssi_clk) t_rise = $time;
  // A long high stretch marks a new frame; the word is frozen there
  always @(negedge ssi_clk) begin
    if ($time - t_rise > 5000) begin
      k = 1;
      sw = ssi_word;
    end else begin
      k++;
    end
    if (k >= 2 && k <= ssi_bits + 1) begin
      ssi_data = sw[ssi_bits + 1 - k];
    end else if (k > 1) begin
      ssi_data = ~ssi_data;
    end
  end
  // Silent until asked; one wait bit, then start and data
  always @(posedge rr_oe) begin
    j = 0;
    rw = rr_word;
    rr_data = 1'b0;
  end
  always @(negedge rr_clk) begin
    #1;
    if (j >= 0 && !rr_oe) begin
      j++;
      if (j == 2) begin
        rr_data = 1'b1;
      end else if (j > 2 && j <= rr_bits + 2) begin
        rr_data = rw[rr_bits + 2 - j];
      end
    end
  end
  // Released after the last bit: the line shows the inverse, not a held bit
  always @(posedge rr_clk) begin
    if (j == rr_bits + 2) begin
      #1;
      rr_data = ~rr_data;
      j = -1;
    end
  end
endmodule : axenc_enc_model
`default_nettype wire

// *** bench/test_axis_encoder_interface.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_axis_encoder_interface;
  import axenc_pkg::*;
  localparam int RR_CYC = 6000;
  localparam logic [31:0] DEM = 32'h0000_1000;
  logic REF_CLK, NRST, GRAY_SELECT, ENC_A, ENC_B, ENC_Z;
  logic [7:0] AXIS_TYPE_SELECT;
  logic [1:0] SERVO_PERIOD_SEL;
  logic [4:0] SSI_BIT_COUNT;
  logic [5:0] RR_BIT_COUNT;
  logic [31:0] DEMAND_POSITION, MEASURED_POSITION, POSITION_ERROR, INDEX_POSITION;
  logic SSI_DATA, RR_DATA_IN, SSI_CLK, RR_CLK, RR_DATA_OUT, RR_DATA_OE;
  logic QOUT_A, QOUT_B, POSITION_VALID, PERIOD_ERROR, enc_rr;
  logic [31:0] ssi_word = 32'h0;
  logic [31:0] rr_word = 32'h0;
  logic qa_q = 1'b0;
  logic qb_q = 1'b0;
  int qedges = 0;
  int num_errors = 0;
  int compares = 0;
  int exp_cnt = 0;
  logic [1:0] qs = 2'h0;
  // Device drives the shared data line only while its enable is high
  assign RR_DATA_IN = RR_DATA_OE ? RR_DATA_OUT : enc_rr;
  axenc_top #(.RR_CYCLE(RR_CYC)) dut (.REF_CLK(REF_CLK), .NRST(NRST),
    .AXIS_TYPE_SELECT(AXIS_TYPE_SELECT), .SERVO_PERIOD_SEL(SERVO_PERIOD_SEL),
    .SSI_BIT_COUNT(SSI_BIT_COUNT), .GRAY_SELECT(GRAY_SELECT),
    .RR_BIT_COUNT(RR_BIT_COUNT), .DEMAND_POSITION(DEMAND_POSITION),
    .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_Z(ENC_Z), .SSI_DATA(SSI_DATA),
    .RR_DATA_IN(RR_DATA_IN), .SSI_CLK(SSI_CLK), .RR_CLK(RR_CLK),
    .RR_DATA_OUT(RR_DATA_OUT), .RR_DATA_OE(RR_DATA_OE), .QOUT_A(QOUT_A),
    .QOUT_B(QOUT_B), .MEASURED_POSITION(MEASURED_POSITION),
    .POSITION_ERROR(POSITION_ERROR), .POSITION_VALID(POSITION_VALID),
    .INDEX_POSITION(INDEX_POSITION), .PERIOD_ERROR(PERIOD_ERROR));
  axenc_enc_model enc (.ssi_clk(SSI_CLK), .ssi_bits(SSI_BIT_COUNT),
    .ssi_word(ssi_word), .ssi_data(SSI_DATA), .rr_clk(RR_CLK),
    .rr_oe(RR_DATA_OE), .rr_bits(RR_BIT_COUNT), .rr_word(rr_word),
    .rr_data(enc_rr));
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    qa_q <= QOUT_A;
    qb_q <= QOUT_B;
    if (NRST && ((QOUT_A !== qa_q) || (QOUT_B !== qb_q))) qedges <= qedges + 1;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // ***************************************************
  // Scenarios
  // ***************************************************
  // Edges 160 ns apart, the fastest rate the decoder must follow
  task automatic quad(input int steps, input bit up);
    repeat (steps) begin
      qs = up ? qs + 2'h1 : qs - 2'h1;
      ENC_A <= (qs == 2'h1) || (qs == 2'h2);
      ENC_B <= qs[1];
      exp_cnt = up ? exp_cnt + 1 : exp_cnt - 1;
      repeat (16) @(posedge REF_CLK);
    end
    repeat (8) @(posedge REF_CLK);
  endtask : quad
  task automatic t_qout();
    quad(6, 1'b1);
    chk("count up", exp_cnt, MEASURED_POSITION);
    repeat (200) @(posedge REF_CLK);
    chk("pulse edges", 6, qedges);
    quad(2, 1'b0);
    repeat (200) @(posedge REF_CLK);
    chk("count down", exp_cnt, MEASURED_POSITION);
    chk("pulse edges back", 8, qedges);
    chk("error", DEM - exp_cnt, POSITION_ERROR);
    chk("valid level", 1, POSITION_VALID);
    $display("test qout done");
  endtask : t_qout
  task automatic t_index();
    AXIS_TYPE_SELECT <= AXT_SERVO;
    quad(5, 1'b1);
    ENC_Z <= 1'b1;
    repeat (16) @(posedge REF_CLK);
    ENC_Z <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    chk("index", exp_cnt, INDEX_POSITION);
    chk("servo count", exp_cnt, MEASURED_POSITION);
    quad(3, 1'b0);
    chk("index held", exp_cnt + 3, INDEX_POSITION);
    chk("servo down", exp_cnt, MEASURED_POSITION);
    $display("test index done");
  endtask : t_index
  task automatic t_ssi(input int n, input logic [31:0] pos, input bit gray);
    int run, falls, bad, vld;
    logic prev;
    ssi_word = gray ? pos ^ (pos >> 1) : pos;
    GRAY_SELECT <= gray;
    SSI_BIT_COUNT <= n[4:0];
    AXIS_TYPE_SELECT <= AXT_SSI_ABS;
    run = 0;
    while (run < 1000) begin
      @(posedge REF_CLK);
      run = SSI_CLK ? run + 1 : 0;
    end
    while (SSI_CLK) @(posedge REF_CLK);
    prev = 1'b0;
    run = 0;
    falls = 1;
    bad = 0;
    vld = 0;
    while (!prev || run < 400) begin
      @(posedge REF_CLK);
      run++;
      vld += POSITION_VALID;
      if (SSI_CLK !== prev) begin
        if (run != SSI_HALF_CYC) bad++;
        falls += prev;
        prev = SSI_CLK;
        run = 0;
      end
    end
    while (SSI_CLK) begin
      @(posedge REF_CLK);
      run++;
    end
    chk("pulses", n + 2, falls);
    chk("half periods", 0, bad);
    chk("gap", SSI_GAP_CYC, run);
    chk("ssi word", pos, MEASURED_POSITION);
    chk("ssi error", DEM - pos, POSITION_ERROR);
    chk("valid pulse", 1, vld);
    $display("test serial n=%0d done", n);
  endtask : t_ssi
  task automatic t_halt();
    int lows;
    lows = 0;
    SERVO_PERIOD_SEL <= SERVO_250US;
    repeat (8) @(posedge REF_CLK);
    chk("period flag", 1, PERIOD_ERROR);
    repeat (4000) begin
      @(posedge REF_CLK);
      lows += !SSI_CLK;
    end
    chk("halted clock", 0, lows);
    SERVO_PERIOD_SEL <= 2'h1;
    repeat (8) @(posedge REF_CLK);
    chk("period clear", 0, PERIOD_ERROR);
    $display("test halt done");
  endtask : t_halt
  task automatic t_rr();
    int t, half;
    logic [5:0] cmd;
    logic pclk;
    rr_word = 32'hc3a5_1e69;
    RR_BIT_COUNT <= 6'h20;
    AXIS_TYPE_SELECT <= AXT_RR_ABS;
    while (!RR_DATA_OE) @(posedge REF_CLK);
    t = 0;
    while (!RR_CLK) begin
      @(posedge REF_CLK);
      t++;
    end
    half = t;
    // Command bits are taken on the link clock's rising edges while driven
    cmd = {5'h00, RR_DATA_OUT};
    pclk = 1'b1;
    while (RR_DATA_OE) begin
      @(posedge REF_CLK);
      t++;
      if (RR_CLK && !pclk) cmd = {cmd[4:0], RR_DATA_OUT};
      pclk = RR_CLK;
    end
    while (!RR_DATA_OE) begin
      @(posedge REF_CLK);
      t++;
    end
    chk("link half", RR_HALF_CYC, half);
    chk("request spacing", RR_CYC, t);
    chk("link word", rr_word, MEASURED_POSITION);
    chk("link error", DEM - rr_word, POSITION_ERROR);
    chk("link command", RR_CMD_POS, cmd);
    // Let the spacing check see the second request before the run ends
    repeat (4) @(posedge REF_CLK);
    $display("test link done");
  endtask : t_rr
  initial begin
    NRST <= 1'b0;
    AXIS_TYPE_SELECT <= AXT_ENC_OUT;
    SERVO_PERIOD_SEL <= 2'h1;
    SSI_BIT_COUNT <= 5'h0c;
    GRAY_SELECT <= 1'b0;
    RR_BIT_COUNT <= 6'h20;
    DEMAND_POSITION <= DEM;
    ENC_A <= 1'b0;
    ENC_B <= 1'b0;
    ENC_Z <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    chk("reset clocks", 2'h3, {SSI_CLK, RR_CLK});
    chk("reset enable", 0, RR_DATA_OE);
    NRST <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    t_qout();
    t_index();
    t_ssi(12, 32'h0000_0a5c, 1'b0);
    t_ssi(25, 32'h01b3_9e47, 1'b1);
    t_halt();
    t_rr();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge REF_CLK);
    num_errors++;
    stop_test();
  end
endmodule : test_axis_encoder_interface
`default_nettype wire
